// >>> common/timers_defs.svh
`ifndef TIMERS_DEFS_SVH
`define TIMERS_DEFS_SVH

// Register indices; byte address is four times the index
`define TMR_IDX_CONTROL 10'h088
`define TMR_IDX_MODE 10'h089
`define TMR_IDX_T0_LOW 10'h08A
`define TMR_IDX_T1_LOW 10'h08B
`define TMR_IDX_T0_HIGH 10'h08C
`define TMR_IDX_T1_HIGH 10'h08D
`define TMR_IDX_T2_CONTROL 10'h0C8
`define TMR_IDX_T2_MODE 10'h0C9
`define TMR_IDX_RELOAD_LOW 10'h0CA
`define TMR_IDX_RELOAD_HIGH 10'h0CB
`define TMR_IDX_T2_LOW 10'h0CC
`define TMR_IDX_T2_HIGH 10'h0CD

// Timer control bits
`define TMR_BIT_TF1 7
`define TMR_BIT_TR1 6
`define TMR_BIT_TF0 5
`define TMR_BIT_TR0 4

// Mode register fields
`define TMR_BIT_TIMER1_GATE_ENABLE 7
`define TMR_BIT_CT1 6
`define TMR_POS_MODE1 4
`define TMR_BIT_TIMER0_GATE_ENABLE 3
`define TMR_BIT_CT0 2
`define TMR_POS_MODE0 0

// Timer 2 control and mode bits
`define TMR_BIT_TF2 7
`define TMR_BIT_TIMER2_EXT_FLAG 6
`define TMR_BIT_TR2 2
`define TMR_BIT_CT2 1
`define TMR_BIT_CLOCK_OUT_ENABLE 1
`define TMR_BIT_UPDOWN_ENABLE 0

// Reset value of every register byte
`define TMR_RESET_BYTE 8'h00

// Clock dividers in system clock cycles
`define TMR_DIV_T01 12
`define TMR_DIV_T2 6
`define TMR_DIV_T2_OUT 2

`endif

// >>> common/timers_pkg.sv
package timers_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Bit 0 is ext_irq0_pin, bit 5 timer2_ext_control
    typedef struct packed {
        logic timer2_ext_control;
        logic timer2_pin_in;
        logic timer1_ext_input;
        logic timer0_ext_input;
        logic ext_irq1_pin;
        logic ext_irq0_pin;
    } ext_pins_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] t0_low;
        logic [7:0] t0_high;
        logic [7:0] t1_low;
        logic [7:0] t1_high;
        logic tf0;
        logic tr0;
        logic tf1;
        logic tr1;
        logic [7:0] t2_low;
        logic [7:0] t2_high;
        logic [7:0] reload_low;
        logic [7:0] reload_high;
        logic tf2;
        logic timer2_ext_flag;
        logic tr2;
        logic ct2;
        logic clock_out_enable;
        logic updown_enable;
        logic [3:0] div01;
        logic [3:0] div2;
        logic pin_out;
        logic [5:0] sync1;
        logic [5:0] sync2;
        logic [5:0] sync3;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage

// >>> hdl/three_timers.sv
`timescale 1ns/1ps
`include "timers_defs.svh"
// Operation
// - Timer 1 counts while run set (or always while timer 0 is in mode 3), and ext_irq1_pin high if gated.
// - Timer 0 counts while run set, and ext_irq0_pin high if gated.
// - Timer 1 counts divided system clock, or falling edges of its pin.
// - Timer 0 counts divided system clock, or falling edges of its pin.
// - Timer 1 modes: 13-bit, 16-bit, 8-bit auto-reload, halted holding count.
// - Timer 0 modes: 13-bit, 16-bit, 8-bit auto-reload from high byte.
// - Timer 0 mode 3: low byte alone; high byte uses timer 1 run/flag.
// - Mode and four timer 0/1 count bytes read zero after reset.
// - Timer 2 count is two cascaded bytes forming 16 bits.
// - Timer 2 input: clock divided by 6 (by 2 in clock-out), or events on its pin.
// - Timer 2 advances only while its run bit is set.
// - With updown_enable and clock-out off, timer 2 counts up/down by timer2_ext_control.
// - Counting up, FFFFh overflow sets flag, interrupts, loads reload pair.
// - Counting down, reaching reload value sets flag and loads FFFFh.
// - Up/down wrap toggles timer2_ext_flag as 17th bit and also sets flag, interrupts.
// - Clock-out drives 50% square wave on timer2 pin, reloading each overflow.
// - Clock-out overflows raise no interrupt; rate clock/(4*(65536-reload)).
// - Timer 0/1 overflow sets its flag; vectoring to interrupt clears it.
// - Mode 0 ignores low byte top 3 bits; prescaler carry bumps high byte.
module three_timers #(
    parameter int T01_DIV = `TMR_DIV_T01,
    parameter int T2_DIV = `TMR_DIV_T2,
    parameter int T2_OUT_DIV = `TMR_DIV_T2_OUT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave
    input wire timers_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire timers_pkg::ext_pins_t pins,
    output logic timer2_pin_out,
    output logic timer2_pin_oe,
    // Interrupt requests and acknowledges from the vectoring logic
    input wire logic timer0_irq_ack,
    input wire logic timer1_irq_ack,
    output logic timer0_irq,
    output logic timer1_irq,
    output logic timer2_irq
);

    timers_pkg::state_t s;
    timers_pkg::state_t n;

    logic [5:0] fall;
    logic tick01;
    logic tick2;
    logic [1:0] m0;
    logic [1:0] m1;
    logic inc0;
    logic inc1;
    logic inc_th0;
    logic inc2;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [8:0] th0_sum;
    logic set_tf0;
    logic set_tf1;
    logic set_tf2;
    logic [15:0] cnt2;
    logic [15:0] reload2;
    logic access;
    logic wr;
    logic [9:0] idx;
    logic mapped;
    logic [7:0] rd_byte;

    // One step of a timer 0/1 pair, returns {overflow, high, low}
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi,
                                         input logic inc);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        if (inc) begin
            unique case (m)
                2'b00: begin
                    // Top 3 low bits untouched by the 5-bit prescaler
                    r[4:0] = lo[4:0] + 5'h01;
                    if (lo[4:0] == 5'h1F) begin
                        r[16:8] = {1'b0, hi} + 9'h001;
                    end
                end
                2'b01: r = {1'b0, hi, lo} + 17'h00001;
                2'b10: begin
                    if (lo == 8'hFF) begin
                        r = {1'b1, hi, hi};
                    end else begin
                        r[7:0] = lo + 8'h01;
                    end
                end
                2'b11: {r[16], r[7:0]} = {1'b0, lo} + 9'h001;
            endcase
        end
        return r;
    endfunction

    always_comb begin
        n = s;
        // Double sync; third stage only compares the stable second stage
        n.sync1 = pins;
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;
        fall = s.sync3 & ~s.sync2;

        m0 = s.mode[`TMR_POS_MODE0 +: 2];
        m1 = s.mode[`TMR_POS_MODE1 +: 2];

        tick01 = (s.div01 == 4'(T01_DIV - 1));
        n.div01 = tick01 ? 4'h0 : s.div01 + 4'h1;
        // Clock-out counts at half the clock, plain timer at one sixth
        tick2 = s.clock_out_enable ? (s.div2 >= 4'(T2_OUT_DIV - 1)) : (s.div2 >= 4'(T2_DIV - 1));
        n.div2 = tick2 ? 4'h0 : s.div2 + 4'h1;

        // Timer 0 low part
        inc0 = s.tr0 & (~s.mode[`TMR_BIT_TIMER0_GATE_ENABLE] | s.sync2[0])
               & (s.mode[`TMR_BIT_CT0] ? fall[2] : tick01);
        r0 = step(m0, s.t0_low, s.t0_high, inc0);

        // Timer 1 ignores its run bit while timer 0 has borrowed it
        inc1 = ((m0 == 2'b11) | s.tr1) & (~s.mode[`TMR_BIT_TIMER1_GATE_ENABLE] | s.sync2[1])
               & (s.mode[`TMR_BIT_CT1] ? fall[3] : tick01)
               & (m1 != 2'b11);
        r1 = step(m1, s.t1_low, s.t1_high, inc1);

        // Timer 0 high byte as a separate timer in mode 3
        inc_th0 = (m0 == 2'b11) & s.tr1 & tick01;
        th0_sum = {1'b0, s.t0_high} + {8'h00, inc_th0};

        n.t0_low = r0[7:0];
        n.t0_high = (m0 == 2'b11) ? th0_sum[7:0] : r0[15:8];
        n.t1_low = r1[7:0];
        n.t1_high = r1[15:8];

        set_tf0 = r0[16];
        set_tf1 = (m0 == 2'b11) ? th0_sum[8] : r1[16];
        // Set wins over the acknowledge clear
        n.tf0 = (s.tf0 & ~timer0_irq_ack) | set_tf0;
        n.tf1 = (s.tf1 & ~timer1_irq_ack) | set_tf1;

        // Timer 2
        cnt2 = {s.t2_high, s.t2_low};
        reload2 = {s.reload_high, s.reload_low};
        inc2 = s.tr2 & (s.ct2 ? fall[4] : tick2);
        set_tf2 = 1'b0;
        if (inc2) begin
            if (s.updown_enable & ~s.clock_out_enable & ~s.sync2[5]) begin
                if (cnt2 == reload2) begin
                    cnt2 = 16'hFFFF;
                    set_tf2 = 1'b1;
                    n.timer2_ext_flag = ~s.timer2_ext_flag;
                end else begin
                    cnt2 = cnt2 - 16'h0001;
                end
            end else if (cnt2 == 16'hFFFF) begin
                cnt2 = reload2;
                if (s.clock_out_enable) begin
                    n.pin_out = ~s.pin_out;
                end else begin
                    set_tf2 = 1'b1;
                    if (s.updown_enable) begin
                        n.timer2_ext_flag = ~s.timer2_ext_flag;
                    end
                end
            end else begin
                cnt2 = cnt2 + 16'h0001;
            end
        end
        n.t2_low = cnt2[7:0];
        n.t2_high = cnt2[15:8];
        n.tf2 = s.tf2 | set_tf2;

        // APB: one wait state, answer on the second access cycle
        access = apb_req.psel & apb_req.penable;
        idx = apb_req.paddr[11:2];
        wr = access & s.pready & apb_req.pwrite;
        mapped = (apb_req.paddr[1:0] == 2'b00);
        rd_byte = `TMR_RESET_BYTE;
        unique case (idx)
            `TMR_IDX_CONTROL: rd_byte = {s.tf1, s.tr1, s.tf0, s.tr0, 4'h0};
            `TMR_IDX_MODE: rd_byte = s.mode;
            `TMR_IDX_T0_LOW: rd_byte = s.t0_low;
            `TMR_IDX_T1_LOW: rd_byte = s.t1_low;
            `TMR_IDX_T0_HIGH: rd_byte = s.t0_high;
            `TMR_IDX_T1_HIGH: rd_byte = s.t1_high;
            `TMR_IDX_T2_CONTROL: rd_byte = {s.tf2, s.timer2_ext_flag, 3'h0, s.tr2, s.ct2, 1'b0};
            `TMR_IDX_T2_MODE: rd_byte = {6'h00, s.clock_out_enable, s.updown_enable};
            `TMR_IDX_RELOAD_LOW: rd_byte = s.reload_low;
            `TMR_IDX_RELOAD_HIGH: rd_byte = s.reload_high;
            `TMR_IDX_T2_LOW: rd_byte = s.t2_low;
            `TMR_IDX_T2_HIGH: rd_byte = s.t2_high;
            default: mapped = 1'b0;
        endcase
        n.pready = access & ~s.pready;
        if (access & ~s.pready) begin
            n.prdata = (mapped & ~apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            n.pslverr = ~mapped;
        end else begin
            n.pslverr = 1'b0;
        end

        // Writes after the hardware update so software keeps its value, but a flag set in the same cycle still wins
        if (wr & mapped) begin
            unique case (idx)
                `TMR_IDX_CONTROL: begin
                    n.tf1 = apb_req.pwdata[`TMR_BIT_TF1] | set_tf1;
                    n.tr1 = apb_req.pwdata[`TMR_BIT_TR1];
                    n.tf0 = apb_req.pwdata[`TMR_BIT_TF0] | set_tf0;
                    n.tr0 = apb_req.pwdata[`TMR_BIT_TR0];
                end
                `TMR_IDX_MODE: n.mode = apb_req.pwdata[7:0];
                `TMR_IDX_T0_LOW: n.t0_low = apb_req.pwdata[7:0];
                `TMR_IDX_T1_LOW: n.t1_low = apb_req.pwdata[7:0];
                `TMR_IDX_T0_HIGH: n.t0_high = apb_req.pwdata[7:0];
                `TMR_IDX_T1_HIGH: n.t1_high = apb_req.pwdata[7:0];
                `TMR_IDX_T2_CONTROL: begin
                    n.tf2 = apb_req.pwdata[`TMR_BIT_TF2] | set_tf2;
                    n.timer2_ext_flag = apb_req.pwdata[`TMR_BIT_TIMER2_EXT_FLAG];
                    n.tr2 = apb_req.pwdata[`TMR_BIT_TR2];
                    n.ct2 = apb_req.pwdata[`TMR_BIT_CT2];
                end
                `TMR_IDX_T2_MODE: begin
                    n.clock_out_enable = apb_req.pwdata[`TMR_BIT_CLOCK_OUT_ENABLE];
                    n.updown_enable = apb_req.pwdata[`TMR_BIT_UPDOWN_ENABLE];
                end
                `TMR_IDX_RELOAD_LOW: n.reload_low = apb_req.pwdata[7:0];
                `TMR_IDX_RELOAD_HIGH: n.reload_high = apb_req.pwdata[7:0];
                `TMR_IDX_T2_LOW: n.t2_low = apb_req.pwdata[7:0];
                `TMR_IDX_T2_HIGH: n.t2_high = apb_req.pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign timer2_pin_out = s.pin_out;
    assign timer2_pin_oe = s.clock_out_enable;
    assign timer0_irq = s.tf0;
    assign timer1_irq = s.tf1;
    // Clock-out overflows never reach this line; up/down wraps that toggle timer2_ext_flag do
    assign timer2_irq = s.tf2;

endmodule

// >>> tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    // Clock
    input wire logic ref_clk,
    // Bench requests
    input wire logic [2:0] lvl,
    input wire logic [2:0] sel,
    input wire logic [3:0] n_edges,
    input wire logic go,
    // Pins to the block
    output timers_pkg::ext_pins_t pins
);
    logic [5:0] cnt_reg = 6'h00;
    logic [2:0] sel_reg = 3'h0;
    logic p;
    // Two cycles low, two high: no edge too short to catch
    assign p = (cnt_reg == 6'h00) | ~cnt_reg[1];
    always_ff @(posedge ref_clk) begin
        if (go) begin
            cnt_reg <= {n_edges, 2'h0};
            sel_reg <= sel;
        end else if (cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
        end
    end
    // Count inputs idle high between bursts
    assign pins = {lvl[2], sel_reg[2] ? p : 1'h1, sel_reg[1] ? p : 1'h1, sel_reg[0] ? p : 1'h1, lvl[1:0]};
endmodule

// >>> tb/three_timer_counters_test.sv
`timescale 1ns/1ps
module three_timer_counters_test;
    localparam logic [11:0] a_ctl = 12'h220;
    localparam logic [11:0] a_mode = 12'h224;
    localparam logic [11:0] a_t2c = 12'h320;
    localparam logic [11:0] a_t2m = 12'h324;
    localparam logic [11:0] a_tl [2] = '{12'h228, 12'h22C};
    localparam logic [11:0] a_th [2] = '{12'h230, 12'h234};
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    timers_pkg::apb_req_t apb_req = '0;
    timers_pkg::ext_pins_t pins;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, pin_out, pin_oe, go = 1'h0;
    logic [1:0] ack = 2'h0;
    logic [2:0] irq, lvl = 3'h0, sel = 3'h0;
    logic [3:0] n_edges = 4'h0;
    int n_fail = 0, checked = 0;
    three_timers three_timers_i (.ref_clk(ref_clk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .timer2_pin_out(pin_out), .timer2_pin_oe(pin_oe),
        .timer0_irq_ack(ack[0]), .timer1_irq_ack(ack[1]), .timer0_irq(irq[0]), .timer1_irq(irq[1]),
        .timer2_irq(irq[2]));
    pin_model pin_model_i (.ref_clk(ref_clk), .lvl(lvl), .sel(sel), .n_edges(n_edges), .go(go), .pins(pins));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        apb_req <= '{1'h1, 1'h0, wr, a, {24'h000000, d}};
        @(posedge ref_clk);
        apb_req.penable <= 1'h1;
        // No timeout here: pready ends the wait, or else only the watchdog does
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk(rd, {24'h000000, e});
    endtask
    task automatic edges(input logic [2:0] s, input logic [3:0] n);
        sel <= s;
        n_edges <= n;
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
        cyc(4 * n + 10);
    endtask
    task automatic s_reset();
        rchk(a_mode, 8'h00);
        for (int t = 0; t < 2; t++) begin
            rchk(a_tl[t], 8'h00);
            rchk(a_th[t], 8'h00);
        end
        apb(1'h0, 12'hFFC, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        apb(1'h1, 12'h225, 8'h11);
        chk({rd[30:0], err}, 32'h1);
    endtask
    task automatic s_modes();
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                apb(1'h1, a_mode, 8'(m << (4 * t)));
                apb(1'h1, a_tl[t], 8'hFF);
                apb(1'h1, a_th[t], m == 2 ? 8'h5A : 8'hFF);
                apb(1'h1, a_ctl, t ? 8'h40 : 8'h10);
                cyc(40);
                chk(32'(irq[t]), 32'h1);
                @(posedge ref_clk);
                ack[t] <= 1'h1;
                @(posedge ref_clk);
                ack[t] <= 1'h0;
                cyc(2);
                chk(32'(irq[t]), 32'h0);
                apb(1'h1, a_ctl, 8'h00);
                rchk(a_th[t], m == 2 ? 8'h5A : 8'h00);
            end
        end
    endtask
    task automatic s_mode3();
        apb(1'h1, a_mode, 8'h33);
        apb(1'h1, a_th[0], 8'hFF);
        apb(1'h1, a_tl[1], 8'hFF);
        apb(1'h1, a_ctl, 8'h40);
        cyc(40);
        chk(32'(irq), 32'h2);
        rchk(a_tl[1], 8'hFF);
        apb(1'h1, a_ctl, 8'h00);
    endtask
    task automatic s_gate_count();
        for (int t = 0; t < 2; t++) begin
            apb(1'h1, a_mode, t ? 8'hD0 : 8'h0D);
            apb(1'h1, a_tl[t], 8'h00);
            apb(1'h1, a_ctl, t ? 8'h40 : 8'h10);
            edges(3'(1 << t), 4'h3);
            rchk(a_tl[t], 8'h00);
            lvl[t] <= 1'h1;
            edges(3'(1 << t), 4'h5);
            rchk(a_tl[t], 8'h05);
            lvl[t] <= 1'h0;
            apb(1'h1, a_ctl, 8'h00);
        end
    endtask
    task automatic s_t2();
        for (int d = 1; d >= 0; d--) begin
            lvl[2] <= d[0];
            apb(1'h1, a_t2m, 8'h01);
            apb(1'h1, 12'h328, 8'h34);
            apb(1'h1, 12'h32C, 8'h12);
            apb(1'h1, 12'h330, d ? 8'hFE : 8'h34);
            apb(1'h1, 12'h334, d ? 8'hFF : 8'h12);
            apb(1'h1, a_t2c, 8'h06);
            edges(3'h4, d ? 4'h2 : 4'h1);
            chk(32'(irq[2]), 32'h1);
            rchk(12'h330, d ? 8'h34 : 8'hFF);
            rchk(12'h334, d ? 8'h12 : 8'hFF);
            rchk(a_t2c, 8'hC6);
            apb(1'h1, a_t2c, 8'h00);
        end
    endtask
    task automatic s_clkout();
        int n;
        logic p;
        n = 0;
        apb(1'h1, a_t2m, 8'h02);
        apb(1'h1, 12'h328, 8'hFE);
        apb(1'h1, 12'h32C, 8'hFF);
        apb(1'h1, 12'h330, 8'hFE);
        apb(1'h1, 12'h334, 8'hFF);
        apb(1'h1, a_t2c, 8'h04);
        cyc(8);
        p = pin_out;
        repeat (80) begin
            @(posedge ref_clk);
            n += int'(pin_out !== p);
            p = pin_out;
        end
        chk(32'(n >= 19 && n <= 21), 32'h1);
        chk({30'h0, pin_oe, irq[2]}, 32'h2);
    endtask
    task automatic finish_test();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        cyc(4);
        resetn <= 1'h1;
        s_reset();
        s_modes();
        s_mode3();
        s_gate_count();
        s_t2();
        s_clkout();
        finish_test();
    end
    initial begin
        cyc(20000);
        n_fail++;
        finish_test();
    end
endmodule

// >>> tb/three_timers_props.sv
`timescale 1ns/1ps
module three_timers_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus
    input wire timers_pkg::apb_req_t apb_req,
    input wire logic pready,
    input wire logic pslverr,
    // Pin and interrupts
    input wire logic timer2_pin_oe,
    input wire logic timer0_irq_ack,
    input wire logic timer0_irq,
    input wire logic timer2_irq
);
    logic wr_done;
    assign wr_done = pready & apb_req.pwrite;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    ready_time_a: assert property (apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable |=> pready)
        else $error("pready late");
    bad_addr_a: assert property (pready && apb_req.paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned not refused");
    out_reset_a: assert property ($past(!resetn) |-> !(pready | timer0_irq | timer2_irq | timer2_pin_oe))
        else $error("output set after reset");
    flag0_clear_a: assert property ($fell(timer0_irq) |-> $past(timer0_irq_ack) || $past(wr_done))
        else $error("timer0 flag lost");
    flag2_clear_a: assert property ($fell(timer2_irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("timer2 flag lost");
    clkout_quiet_a: assert property ($rose(timer2_irq) |-> !timer2_pin_oe || $past(wr_done) || $past(wr_done, 2))
        else $error("clock-out interrupt");
    oe_by_write_a: assert property ($changed(timer2_pin_oe) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("pin enable moved");
endmodule
bind three_timers three_timers_props three_timers_props_i (.ref_clk(ref_clk), .resetn(resetn), .apb_req(apb_req),
    .pready(pready), .pslverr(pslverr), .timer2_pin_oe(timer2_pin_oe), .timer0_irq_ack(timer0_irq_ack),
    .timer0_irq(timer0_irq), .timer2_irq(timer2_irq));
